// [hw/dbf_pkg.sv]
// Package for the loop bandwidth and frequency configuration bank.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package dbf_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] DBF_IDX_MAIN_FREQ = 8'h65;
  localparam logic [7:0] DBF_IDX_SEC_BW = 8'h66;
  localparam logic [7:0] DBF_IDX_MAIN_LOCKED_BW = 8'h67;
  localparam int DBF_ADDR_W = 12;
  localparam logic [DBF_ADDR_W-1:0] DBF_ADDR_MAIN_FREQ = {2'h0, DBF_IDX_MAIN_FREQ, 2'h0};
  localparam logic [DBF_ADDR_W-1:0] DBF_ADDR_SEC_BW = {2'h0, DBF_IDX_SEC_BW, 2'h0};
  localparam logic [DBF_ADDR_W-1:0] DBF_ADDR_MAIN_LOCKED_BW = {2'h0, DBF_IDX_MAIN_LOCKED_BW, 2'h0};

  // Field positions and widths
  localparam int DBF_FREQ_LSB = 0;
  localparam int DBF_FREQ_W = 3;
  localparam int DBF_SEC_BW_LSB = 0;
  localparam int DBF_SEC_BW_W = 2;
  localparam int DBF_LOCK_BW_LSB = 0;
  localparam int DBF_LOCK_BW_W = 4;

  // Reset values
  localparam logic [DBF_FREQ_W-1:0] DBF_FREQ_RST = 3'h0;
  localparam logic [DBF_SEC_BW_W-1:0] DBF_SEC_BW_RST = 2'h0;
  localparam logic [DBF_LOCK_BW_W-1:0] DBF_LOCK_BW_RST = 4'hb;

  // Frequency codes of the main loop
  typedef enum logic [2:0] {
    DBF_FREQ_C0 = 3'b000,
    DBF_FREQ_C1 = 3'b001,
    DBF_FREQ_TWELVE_E1 = 3'b010,
    DBF_FREQ_SIXTEEN_E1 = 3'b011,
    DBF_FREQ_TWENTYFOUR_DS1 = 3'b100,
    DBF_FREQ_SIXTEEN_DS1 = 3'b101,
    DBF_FREQ_U6 = 3'b110,
    DBF_FREQ_U7 = 3'b111
  } dbf_freq_e;

  // Analog PLL output before dividers, in kHz
  localparam int DBF_KHZ_W = 18;
  localparam logic [DBF_KHZ_W-1:0] DBF_KHZ_TWELVE_E1 = 18'h18000;
  localparam logic [DBF_KHZ_W-1:0] DBF_KHZ_SIXTEEN_E1 = 18'h20000;
  localparam logic [DBF_KHZ_W-1:0] DBF_KHZ_TWENTYFOUR_DS1 = 18'h24300;
  localparam logic [DBF_KHZ_W-1:0] DBF_KHZ_SIXTEEN_DS1 = 18'h18200;

  // Bandwidths in tenths of a hertz
  localparam int DBF_BW_W = 10;
  localparam logic [DBF_BW_W-1:0] DBF_BW_0P3 = 10'h003;
  localparam logic [DBF_BW_W-1:0] DBF_BW_0P6 = 10'h006;
  localparam logic [DBF_BW_W-1:0] DBF_BW_1P2 = 10'h00c;
  localparam logic [DBF_BW_W-1:0] DBF_BW_2P5 = 10'h019;
  localparam logic [DBF_BW_W-1:0] DBF_BW_4 = 10'h028;
  localparam logic [DBF_BW_W-1:0] DBF_BW_8 = 10'h050;
  localparam logic [DBF_BW_W-1:0] DBF_BW_18 = 10'h0b4;
  localparam logic [DBF_BW_W-1:0] DBF_BW_35 = 10'h15e;
  localparam logic [DBF_BW_W-1:0] DBF_BW_70 = 10'h2bc;
endpackage : dbf_pkg

// [hw/dbf_regs.sv]
// Configuration bank: main loop frequency mode, secondary loop bandwidth
// and main loop locked bandwidth, reached over APB with zero wait states.
// Assumes pclk and presetn come from the same domain as the APB master.
`timescale 1ns/1ps
module dbf_regs (
  input wire logic pclk, // System clock, 50 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high for write
  input wire logic [dbf_pkg::DBF_ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB write byte strobes
  output logic [31:0] prdata, // APB read data, registered
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  output logic [2:0] main_loop_freq_field, // Effective main loop frequency code
  output logic twelve_e1_mode, // Main loop in twelve E1 mode
  output logic sixteen_e1_mode, // Main loop in sixteen E1 mode
  output logic twentyfour_ds1_mode, // Main loop in twenty-four DS1 mode
  output logic sixteen_ds1_mode, // Main loop in sixteen DS1 mode
  output logic [dbf_pkg::DBF_KHZ_W-1:0] apll_khz, // Analog PLL output, kHz, 0 if digital
  output logic [1:0] secondary_loop_bw_field, // Effective secondary bandwidth code
  output logic [dbf_pkg::DBF_BW_W-1:0] secondary_bw_tenth_hz, // Secondary bandwidth
  output logic [3:0] main_loop_locked_bw_field, // Effective locked bandwidth code
  output logic [dbf_pkg::DBF_BW_W-1:0] main_locked_bw_tenth_hz // Locked bandwidth
);
  import dbf_pkg::*;

  logic [DBF_FREQ_W-1:0] freq_q;
  logic [DBF_SEC_BW_W-1:0] sec_bw_q;
  logic [DBF_LOCK_BW_W-1:0] lock_bw_q;
  logic [DBF_FREQ_W-1:0] freq_eff_q;
  logic [DBF_SEC_BW_W-1:0] sec_eff_q;
  logic [DBF_LOCK_BW_W-1:0] lock_eff_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic err_q;
  logic hit;
  logic wr_en;
  logic setup;

  // Main loop frequency code to analog PLL output; digital codes give zero
  function automatic logic [DBF_KHZ_W-1:0] freq_khz(input logic [2:0] code);
    case (code)
      DBF_FREQ_TWELVE_E1: freq_khz = DBF_KHZ_TWELVE_E1;
      DBF_FREQ_SIXTEEN_E1: freq_khz = DBF_KHZ_SIXTEEN_E1;
      DBF_FREQ_TWENTYFOUR_DS1: freq_khz = DBF_KHZ_TWENTYFOUR_DS1;
      DBF_FREQ_SIXTEEN_DS1: freq_khz = DBF_KHZ_SIXTEEN_DS1;
      default: freq_khz = '0;
    endcase
  endfunction : freq_khz

  // Locked bandwidth code to tenths of a hertz; zero marks an unused code
  function automatic logic [DBF_BW_W-1:0] lock_bw(input logic [3:0] code);
    case (code)
      4'h8: lock_bw = DBF_BW_0P3;
      4'h9: lock_bw = DBF_BW_0P6;
      4'ha: lock_bw = DBF_BW_1P2;
      4'hb: lock_bw = DBF_BW_2P5;
      4'hc: lock_bw = DBF_BW_4;
      4'hd: lock_bw = DBF_BW_8;
      4'he: lock_bw = DBF_BW_18;
      4'hf: lock_bw = DBF_BW_35;
      default: lock_bw = '0;
    endcase
  endfunction : lock_bw

  // Secondary bandwidth code to tenths of a hertz; zero marks code 11
  function automatic logic [DBF_BW_W-1:0] sec_bw(input logic [1:0] code);
    case (code)
      2'h0: sec_bw = DBF_BW_18;
      2'h1: sec_bw = DBF_BW_35;
      2'h2: sec_bw = DBF_BW_70;
      default: sec_bw = '0;
    endcase
  endfunction : sec_bw

  // Bus decode; a write takes effect on the access edge only
  assign setup = psel && !penable;
  assign hit = (paddr == DBF_ADDR_MAIN_FREQ) || (paddr == DBF_ADDR_SEC_BW) ||
               (paddr == DBF_ADDR_MAIN_LOCKED_BW);
  assign wr_en = psel && penable && pwrite && hit && pstrb[0];
  assign pready = 1'b1;
  assign pslverr = err_q && psel && penable;
  assign prdata = rdata_q;

  // Stored fields; only the low lane carries data, upper bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_q <= DBF_FREQ_RST;
      sec_bw_q <= DBF_SEC_BW_RST;
      lock_bw_q <= DBF_LOCK_BW_RST;
    end else if (wr_en) begin
      case (paddr)
        DBF_ADDR_MAIN_FREQ: freq_q <= pwdata[DBF_FREQ_LSB +: DBF_FREQ_W];
        DBF_ADDR_SEC_BW: sec_bw_q <= pwdata[DBF_SEC_BW_LSB +: DBF_SEC_BW_W];
        DBF_ADDR_MAIN_LOCKED_BW: lock_bw_q <= pwdata[DBF_LOCK_BW_LSB +: DBF_LOCK_BW_W];
        default: freq_q <= freq_q;
      endcase
    end
  end

  // Read mux; fields sit in the low bits, everything above reads zero
  always_comb begin
    rdata_d = '0;
    case (paddr)
      DBF_ADDR_MAIN_FREQ: rdata_d[DBF_FREQ_LSB +: DBF_FREQ_W] = freq_q;
      DBF_ADDR_SEC_BW: rdata_d[DBF_SEC_BW_LSB +: DBF_SEC_BW_W] = sec_bw_q;
      DBF_ADDR_MAIN_LOCKED_BW: rdata_d[DBF_LOCK_BW_LSB +: DBF_LOCK_BW_W] = lock_bw_q;
      default: rdata_d = '0;
    endcase
  end

  // Read data and error are captured in the setup cycle so they stand
  // from a flop through the whole zero-wait access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite ? 32'h0 : rdata_d;
      err_q <= !hit;
    end
  end

  // Effective frequency mode; unused codes 110 and 111 keep the last
  // valid mode so the loop never jumps to an undefined setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_eff_q <= DBF_FREQ_RST;
    end else if (freq_q != DBF_FREQ_U6 && freq_q != DBF_FREQ_U7) begin
      freq_eff_q <= freq_q;
    end
  end

  // Effective secondary bandwidth; code 11 holds the last valid one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_eff_q <= DBF_SEC_BW_RST;
    end else if (sec_bw(sec_bw_q) != '0) begin
      sec_eff_q <= sec_bw_q;
    end
  end

  // Effective locked bandwidth; codes below 1000 hold the last valid one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_eff_q <= DBF_LOCK_BW_RST;
    end else if (lock_bw(lock_bw_q) != '0) begin
      lock_eff_q <= lock_bw_q;
    end
  end

  // Decoded outputs, all from the effective flops
  assign main_loop_freq_field = freq_eff_q;
  assign twelve_e1_mode = (freq_eff_q == DBF_FREQ_TWELVE_E1);
  assign sixteen_e1_mode = (freq_eff_q == DBF_FREQ_SIXTEEN_E1);
  assign twentyfour_ds1_mode = (freq_eff_q == DBF_FREQ_TWENTYFOUR_DS1);
  assign sixteen_ds1_mode = (freq_eff_q == DBF_FREQ_SIXTEEN_DS1);
  assign apll_khz = freq_khz(freq_eff_q);
  assign secondary_loop_bw_field = sec_eff_q;
  assign secondary_bw_tenth_hz = sec_bw(sec_eff_q);
  assign main_loop_locked_bw_field = lock_eff_q;
  assign main_locked_bw_tenth_hz = lock_bw(lock_eff_q);

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wr_freq(logic [2:0] c);
    wr_en && paddr == DBF_ADDR_MAIN_FREQ && pwdata[2:0] == c;
  endsequence

  a_mode_twelve: assert property (s_wr_freq(3'b010) |-> ##2 twelve_e1_mode &&
      apll_khz == 18'h18000) else $error("twelve E1 mode not selected");
  a_mode_sixteen: assert property (s_wr_freq(3'b011) |-> ##2 sixteen_e1_mode &&
      apll_khz == 18'h20000) else $error("sixteen E1 mode not selected");
  a_unused_hold: assert property ((s_wr_freq(3'b110) or s_wr_freq(3'b111))
      |-> ##1 $stable(main_loop_freq_field)[*2]) else $error("unused code changed mode");
  a_mode_sixteen_ds1: assert property (s_wr_freq(3'b101) |-> ##2 sixteen_ds1_mode &&
      apll_khz == 18'h18200) else $error("sixteen DS1 mode not selected");
  a_sec_bw_map: assert property (secondary_bw_tenth_hz ==
      (secondary_loop_bw_field == 2'h2 ? 10'h2bc : secondary_loop_bw_field == 2'h1 ?
      10'h15e : 10'h0b4)) else $error("secondary bandwidth mapping wrong");
  a_sec_rw: assert property (wr_en && paddr == DBF_ADDR_SEC_BW ##1
      psel && !penable && !pwrite && paddr == DBF_ADDR_SEC_BW |=> prdata[1:0] ==
      $past(pwdata[1:0], 2)) else $error("secondary bandwidth readback wrong");
  a_lock_low: assert property (main_loop_locked_bw_field[3] &&
      !main_loop_locked_bw_field[2] |-> main_locked_bw_tenth_hz inside {10'h003, 10'h006,
      10'h00c, 10'h019}) else $error("locked low bandwidth mapping wrong");
  a_lock_high: assert property (main_loop_locked_bw_field == 4'hf |->
      main_locked_bw_tenth_hz == 10'h15e) else $error("locked 35 Hz mapping wrong");
  a_upper_zero: assert property (penable && psel && !pwrite |->
      prdata[31:4] == 28'h0) else $error("unused bits read nonzero");
  a_lock_valid: assert property (main_loop_locked_bw_field[3])
    else $error("effective locked code outside valid range");

  // Timing of the checks below: a write lands in the stored field at the
  // access edge and in the effective field one edge later, so the decoded
  // outputs are looked at two edges after the access. Read data is captured
  // at the setup edge and checked one edge later against the stored field.
  sequence s_wr_sec(logic [1:0] c);
    wr_en && paddr == DBF_ADDR_SEC_BW && pwdata[1:0] == c;
  endsequence

  sequence s_wr_lock(logic [3:0] c);
    wr_en && paddr == DBF_ADDR_MAIN_LOCKED_BW && pwdata[3:0] == c;
  endsequence

  sequence s_rd_setup(logic [DBF_ADDR_W-1:0] a);
    psel && !penable && !pwrite && paddr == a;
  endsequence

  // The third analog mode, two edges after the access edge
  a_mode_twentyfour: assert property (s_wr_freq(3'b100) |-> ##2 twentyfour_ds1_mode &&
      apll_khz == 18'h24300) else $error("twenty-four DS1 mode not selected");

  // At most one mode flag, so the dividers never see two modes at once
  a_mode_onehot: assert property ($onehot0({twelve_e1_mode, sixteen_e1_mode,
      twentyfour_ds1_mode, sixteen_ds1_mode})) else $error("more than one mode flag");

  // Digital codes give no analog output and neither the twelve E1 nor the sixteen DS1 flag
  a_mode_digital: assert property (main_loop_freq_field inside {3'b000, 3'b001} |->
      apll_khz == 18'h0 && !twelve_e1_mode && !sixteen_ds1_mode)
    else $error("digital code drove an analog mode");

  // Writing digital code 000 takes the loop out of every analog mode
  a_mode_clear: assert property (s_wr_freq(3'b000) |-> ##2 main_loop_freq_field == 3'b000 &&
      apll_khz == 18'h0) else $error("digital code not taken");

  // Secondary 18 Hz code reaches the effective field
  a_sec_slow: assert property (s_wr_sec(2'h0) |-> ##2 secondary_loop_bw_field == 2'h0 &&
      secondary_bw_tenth_hz == 10'h0b4) else $error("secondary 18 Hz not taken");

  // Secondary 35 Hz code reaches the effective field
  a_sec_mid: assert property (s_wr_sec(2'h1) |-> ##2 secondary_loop_bw_field == 2'h1 &&
      secondary_bw_tenth_hz == 10'h15e) else $error("secondary 35 Hz not taken");

  // Secondary 70 Hz code reaches the effective field
  a_sec_take: assert property (s_wr_sec(2'h2) |-> ##2 secondary_loop_bw_field == 2'h2 &&
      secondary_bw_tenth_hz == 10'h2bc) else $error("secondary 70 Hz not taken");

  // Unused secondary code 11 keeps the loop on its last bandwidth
  a_sec_hold: assert property (s_wr_sec(2'h3) |-> ##1
      $stable(secondary_loop_bw_field)[*2]) else $error("secondary code 11 changed loop");

  // A read of the secondary register returns the stored code, upper bits zero
  a_sec_read: assert property (s_rd_setup(DBF_ADDR_SEC_BW) |=>
      prdata == {30'h0, $past(sec_bw_q)}) else $error("secondary read data wrong");

  // Lowest locked bandwidth reaches the effective field
  a_lock_slow: assert property (s_wr_lock(4'h8) |-> ##2 main_loop_locked_bw_field == 4'h8 &&
      main_locked_bw_tenth_hz == 10'h003) else $error("locked 0.3 Hz not taken");

  // Locked 2.5 Hz code, the reset setting, can be selected again
  a_lock_default: assert property (s_wr_lock(4'hb) |-> ##2
      main_locked_bw_tenth_hz == 10'h019) else $error("locked 2.5 Hz not taken");

  // Locked 4 Hz code
  a_lock_four: assert property (s_wr_lock(4'hc) |-> ##2
      main_locked_bw_tenth_hz == 10'h028) else $error("locked 4 Hz not taken");

  // Locked 8 Hz code
  a_lock_eight: assert property (s_wr_lock(4'hd) |-> ##2
      main_locked_bw_tenth_hz == 10'h050) else $error("locked 8 Hz not taken");

  // Locked 18 Hz code
  a_lock_mid: assert property (s_wr_lock(4'he) |-> ##2
      main_locked_bw_tenth_hz == 10'h0b4) else $error("locked 18 Hz not taken");

  // Locked codes 0000 and 0111 keep the last valid bandwidth
  a_lock_hold: assert property ((s_wr_lock(4'h0) or s_wr_lock(4'h7)) |-> ##1
      $stable(main_loop_locked_bw_field)[*2]) else $error("unused locked code changed loop");

  // Locked register read returns the stored code
  a_lock_read: assert property (s_rd_setup(DBF_ADDR_MAIN_LOCKED_BW) |=>
      prdata == {28'h0, $past(lock_bw_q)}) else $error("locked read data wrong");

  // Frequency register read returns the stored code, unused codes included
  a_freq_read: assert property (s_rd_setup(DBF_ADDR_MAIN_FREQ) |=>
      prdata == {29'h0, $past(freq_q)}) else $error("frequency read data wrong");

  // A write with the low strobe off leaves every stored field alone
  a_strb_ignore: assert property (psel && penable && pwrite && !pstrb[0] |=>
      $stable(freq_q) && $stable(sec_bw_q) && $stable(lock_bw_q))
    else $error("write with low strobe off changed a field");

  // Writes read back as zero during their access phase
  a_write_zero: assert property (psel && penable && pwrite |-> prdata == 32'h0)
    else $error("write access drove read data");

  // An unmapped access flags an error and a mapped one never does
  a_err_map: assert property (psel && penable |-> pslverr == !hit)
    else $error("slave error does not match decode");

  // Zero wait states: ready never drops
  a_ready_high: assert property (pready)
    else $error("ready dropped");
endmodule : dbf_regs

// [verification/dbf_regs_tb.sv]
// Self-checking bench for the loop configuration bank, driving APB directly.
// Assumes zero wait states are not relied on: every access waits for pready.
`timescale 1ns/1ps
module dbf_regs_tb;
  import dbf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [DBF_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [3:0] pstrb = '0, mlb;
  logic pready, pslverr, m12e1, m16e1, m24ds1, m16ds1;
  logic [2:0] mlf, sf, ef;
  logic [1:0] slb, ss, es;
  logic [3:0] sl, el;
  logic [DBF_KHZ_W-1:0] khz;
  logic [DBF_BW_W-1:0] sbw, lbw;
  logic [DBF_ADDR_W-1:0] addrs [4] = '{DBF_ADDR_MAIN_FREQ, DBF_ADDR_SEC_BW,
    DBF_ADDR_MAIN_LOCKED_BW, 12'h1a0};
  int mismatches = 0, total_checks = 0, seed = 73744;
  logic [31:0] rw, ra, rd, rs;
  dbf_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .main_loop_freq_field(mlf), .twelve_e1_mode(m12e1),
    .sixteen_e1_mode(m16e1), .twentyfour_ds1_mode(m24ds1), .sixteen_ds1_mode(m16ds1),
    .apll_khz(khz), .secondary_loop_bw_field(slb), .secondary_bw_tenth_hz(sbw),
    .main_loop_locked_bw_field(mlb), .main_locked_bw_tenth_hz(lbw));
  // Free-running 50 MHz clock
  initial begin
    forever #10 pclk = ~pclk;
  end
  function automatic logic [DBF_KHZ_W-1:0] exp_khz(input logic [2:0] c);
    case (c)
      3'h2: return DBF_KHZ_TWELVE_E1;
      3'h3: return DBF_KHZ_SIXTEEN_E1;
      3'h4: return DBF_KHZ_TWENTYFOUR_DS1;
      3'h5: return DBF_KHZ_SIXTEEN_DS1;
      default: return '0;
    endcase
  endfunction : exp_khz
  function automatic logic [DBF_BW_W-1:0] exp_lock(input logic [3:0] c);
    logic [DBF_BW_W-1:0] t [8] = '{DBF_BW_0P3, DBF_BW_0P6, DBF_BW_1P2, DBF_BW_2P5, DBF_BW_4,
      DBF_BW_8, DBF_BW_18, DBF_BW_35};
    return t[c[2:0]];
  endfunction : exp_lock
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Model reset; the effective codes follow the stored reset codes
  task automatic model_reset();
    sf = DBF_FREQ_RST;
    ef = sf;
    ss = 2'h0;
    es = ss;
    sl = 4'hb;
    el = sl;
  endtask : model_reset
  task automatic check_eff();
    chk(mlf, ef, "freq code");
    chk({m12e1, m16e1, m24ds1, m16ds1}, {ef == 3'h2, ef == 3'h3, ef == 3'h4, ef == 3'h5},
      "mode flags");
    chk(khz, exp_khz(ef), "apll khz");
    chk(slb, es, "sec code");
    chk(sbw, es == 2'h0 ? DBF_BW_18 : es == 2'h1 ? DBF_BW_35 : DBF_BW_70, "sec bw");
    chk(mlb, el, "locked code");
    chk(lbw, exp_lock(el), "locked bw");
  endtask : check_eff
  // One APB transfer, compared against the model, then the effective outputs
  task automatic op(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] exp_rd;
    logic mapped;
    int n;
    mapped = (a == DBF_ADDR_MAIN_FREQ) || (a == DBF_ADDR_SEC_BW) || (a == DBF_ADDR_MAIN_LOCKED_BW);
    exp_rd = wr ? 32'h0 : a == DBF_ADDR_MAIN_FREQ ? {29'h0, sf} :
      a == DBF_ADDR_SEC_BW ? {30'h0, ss} : a == DBF_ADDR_MAIN_LOCKED_BW ? {28'h0, sl} : 32'h0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(pready, 32'h1, "ready");
    chk(prdata, exp_rd, "read data");
    chk(pslverr, !mapped, "slave error");
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && mapped && s[0]) begin
      if (a == DBF_ADDR_MAIN_FREQ) sf = d[2:0];
      if (a == DBF_ADDR_SEC_BW) ss = d[1:0];
      if (a == DBF_ADDR_MAIN_LOCKED_BW) sl = d[3:0];
      if (sf < 3'h6) ef = sf;
      if (ss != 2'h3) es = ss;
      if (sl[3]) el = sl;
    end
    repeat (2) @(posedge pclk);
    #1 check_eff();
  endtask : op
  // Watchdog, far beyond the expected run of about 1230 cycles
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end
  initial begin
    model_reset();
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      #1 check_eff();
      for (int k = 0; k < 4; k++) op(1'b0, addrs[k], 32'h0, 4'h0);
      // Every code with random upper bits, each read back
      for (int i = 0; i < 16; i++) begin
        if (i < 8) op(1'b1, addrs[0], ($random(seed) & ~32'h7) | i, 4'hf);
        if (i < 4) op(1'b1, addrs[1], ($random(seed) & ~32'h3) | i, 4'hf);
        op(1'b1, addrs[2], ($random(seed) & ~32'hf) | i, 4'hf);
        for (int k = 0; k < 3; k++) op(1'b0, addrs[k], 32'h0, 4'h0);
      end
      // Strobe off is ignored; unmapped write refused
      op(1'b1, addrs[2], 32'h9, 4'he);
      op(1'b1, addrs[3], 32'hffff_ffff, 4'hf);
      for (int i = 0; i < 40; i++) begin
        rw = $random(seed);
        ra = $random(seed);
        rd = $random(seed);
        rs = $random(seed);
        op(rw[0], addrs[ra[1:0]], rd, rs[3:0]);
      end
      // Second reset in mid-run restores the defaults
      @(posedge pclk);
      presetn <= 1'b0;
      model_reset();
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
    end
    stop_test();
  end
endmodule : dbf_regs_tb
